// *** core/fpe_consts.svh ***
// constants of the front panel encoder control block
`ifndef FPE_CONSTS_SVH
`define FPE_CONSTS_SVH
// channel map
`define FPE_NUM_CH        5'd20
`define FPE_CH_LAST       5'd19
`define FPE_CH_MIC_LAST   5'd1
`define FPE_CH_IN_LAST    5'd3
`define FPE_CH_LINE_FIRST 5'd4
`define FPE_CH_PHONES     5'd10
`define FPE_CH_COAX       5'd11
`define FPE_CH_OPT_FIRST  5'd12
// step indices: mic 0=0dB, n=n+9 dB; inst n=n/2 dB; out 0=mute, n=n-59 dB
`define FPE_MIC_IDX_MAX   8'd56
`define FPE_MIC_DB_OFS    8'd9
`define FPE_INST_IDX_MAX  8'd36
`define FPE_OUT_IDX_MAX   8'd65
`define FPE_OUT_DB_OFS    8'd59
`define FPE_MUTE_IDX      8'd0
// configuration image
`define FPE_CFG_WORDS     24
`define FPE_CFG_LAST      5'd23
`define FPE_CFG_SYS       5'd20
`define FPE_CFG_LINK      5'd21
`define FPE_CFG_RST       16'h0000
// register map
`define FPE_REG_STATUS    12'h000
`define FPE_REG_CFG_BASE  12'h100
`define FPE_REG_CFG_END   12'h160
// timing
`define FPE_LONG_PRESS_MS 1000
`define FPE_CLK_KHZ       10000
`endif

// *** core/fpe_pkg.sv ***
// types of the front panel encoder control block
package fpe_pkg;
    typedef enum logic {fpe_mode_channel, fpe_mode_level} fpe_mode_t;
    typedef enum logic [1:0] {fpe_nv_load, fpe_nv_idle, fpe_nv_save} fpe_nv_state_t;
    typedef enum logic [2:0] {
        fpe_input_code, fpe_line_out_code, phones_pair_code, coax_digital_out_code,
        fpe_optical_code
    } fpe_class_t;
    // what the display shows
    typedef struct packed {
        logic              link_msg; // show link state instead of level
        logic              link_on;  // link state for the message
        fpe_mode_t         mode;     // active encoder mode
        fpe_class_t        cls;      // channel class code
        logic [3:0]        num;      // channel number, 0 for single outputs
        logic signed [7:0] db;       // whole dB of the setting
        logic              dot;      // half dB marker
        logic              mute;     // output muted
    } fpe_disp_t;
    // nonvolatile memory request
    typedef struct packed {
        logic        req;   // held until ack
        logic        we;    // write when high
        logic [4:0]  addr;  // configuration word
        logic [15:0] wdata; // word to store
    } fpe_nv_req_t;
endpackage

// *** core/fpe_sync3.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module fpe_sync3 #(
    parameter int W = 3
) (
    // clock, reset, enable
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // pins and filtered levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q, s2_q, s3_q; // chain, s1 read only by s2
    logic [W-1:0] q_d;

    // a bit changes only once the second and third stage agree
    always_comb begin
        q_d = (s2_q & s3_q) | (q & (s2_q | s3_q));
    end

    // register chain and filtered output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else if (ce) begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= q_d;
        end
    end
endmodule

// *** core/fpe_ctrl.sv ***
// front panel encoder control with persistent configuration and apb registers
`timescale 1ns/10ps
`include "fpe_consts.svh"
module fpe_ctrl #(
    parameter int unsigned LONG_PRESS_CYC = `FPE_LONG_PRESS_MS * `FPE_CLK_KHZ
) (
    // clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // front panel pins
    input  wire logic                enc_a_pin,
    input  wire logic                enc_b_pin,
    input  wire logic                knob_sw_pin,
    // front panel outputs
    output logic                     mode_led,
    output fpe_pkg::fpe_disp_t       disp,
    // nonvolatile memory port
    output fpe_pkg::fpe_nv_req_t     nv_cmd,
    input  wire logic                nv_ack,
    input  wire logic [15:0]         nv_rdata,
    // applied settings
    output logic      [31:0]         an_gain,
    output logic      [127:0]        mix_level,
    output logic      [15:0]         sys_cfg,
    output logic                     cfg_ready
);
    localparam logic [23:0] LONG_CNT = LONG_PRESS_CYC[23:0];

    // channel pair test: everything but phones and coax pairs left/right
    function automatic logic paired(input logic [4:0] ch);
        return (ch < `FPE_CH_PHONES) || (ch > `FPE_CH_COAX);
    endfunction

    // top step index of a channel
    function automatic logic [7:0] max_idx(input logic [4:0] ch);
        if (ch <= `FPE_CH_MIC_LAST) begin
            return `FPE_MIC_IDX_MAX;
        end else if (ch <= `FPE_CH_IN_LAST) begin
            return `FPE_INST_IDX_MAX;
        end
        return `FPE_OUT_IDX_MAX;
    endfunction

    // keep a stored channel word inside its range
    function automatic logic [15:0] clamp_w(input logic [4:0] i, input logic [15:0] w);
        if (i <= `FPE_CH_LAST && w[7:0] > max_idx(i)) begin
            return {8'h00, max_idx(i)};
        end else if (i <= `FPE_CH_LAST) begin
            return {8'h00, w[7:0]};
        end
        return w;
    endfunction

    // next selectable channel; link skips right channels
    function automatic logic [4:0] ch_step(input logic [4:0] ch, input logic up,
                                           input logic link);
        logic [4:0] n;
        if (up) begin
            n = (ch == `FPE_CH_LAST) ? 5'h00 : ch + 5'h01;
        end else begin
            n = (ch == 5'h00) ? `FPE_CH_LAST : ch - 5'h01;
        end
        if (link && paired(n) && n[0]) begin
            if (up) begin
                n = (n == `FPE_CH_LAST) ? 5'h00 : n + 5'h01;
            end else begin
                n = n - 5'h01;
            end
        end
        return n;
    endfunction

    // state
    fpe_pkg::fpe_mode_t     mode_q, mode_d;       // encoder mode
    fpe_pkg::fpe_nv_state_t nvs_q, nvs_d;         // memory sequencer
    logic [15:0]            cfg_q [`FPE_CFG_WORDS]; // configuration image
    logic [15:0]            cfg_d [`FPE_CFG_WORDS];
    logic [4:0]             sel_q, sel_d;         // selected channel
    logic [4:0]             idx_q, idx_d;         // memory word pointer
    logic                   dirty_q, dirty_d;     // image differs from memory
    logic [23:0]            cnt_q, cnt_d;         // press duration
    logic                   long_q, long_d;       // long press already acted
    logic                   sw_prev_q, a_prev_q;  // edge history
    logic                   msg_q, msg_d;         // link message on display
    fpe_pkg::fpe_nv_req_t   nv_d;
    fpe_pkg::fpe_disp_t     disp_d;
    logic [31:0]            prdata_d;
    // combinational helpers
    logic [2:0]  pins;       // a, b, switch after filtering
    logic        a_rise;     // one detent
    logic        sw_fall;    // knob released
    logic        loading;    // restore in progress
    logic        acc;        // apb access completes
    logic        hit_cfg;    // address in image window
    logic [4:0]  widx;       // image word of the address
    logic [11:0] aofs;       // offset inside image window
    logic        changed;    // any setting changed this cycle
    logic [7:0]  lvl;        // stepped level
    logic [4:0]  dch;        // channel shown
    logic [7:0]  dlvl;       // level of the shown channel

    fpe_sync3 #(.W(3)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({enc_a_pin, enc_b_pin, knob_sw_pin}),
        .q       (pins)
    );

    // apb decode; bus stalls while the image is restored
    always_comb begin
        loading = (nvs_q == fpe_pkg::fpe_nv_load);
        pready  = !loading;
        aofs    = paddr - `FPE_REG_CFG_BASE;
        widx    = aofs[6:2];
        hit_cfg = 1'b0;
        if (paddr >= `FPE_REG_CFG_BASE && paddr < `FPE_REG_CFG_END && paddr[1:0] == 2'b00) begin
            hit_cfg = 1'b1;
        end
        acc     = psel && penable && pready;
        pslverr = acc && !hit_cfg && !(paddr == `FPE_REG_STATUS && !pwrite);
        prdata_d = prdata;
        // keep sampling until the access completes, so a read held over the restore sees it
        if (psel && !acc) begin
            if (paddr == `FPE_REG_STATUS) begin
                prdata_d = {16'h0000, 3'h0, sel_q, 2'h0, nvs_q, dirty_q, msg_q,
                            cfg_q[`FPE_CFG_LINK][0], mode_q};
            end else if (hit_cfg) begin
                prdata_d = {16'h0000, cfg_d[widx]};
            end else begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    // panel, image and memory sequencer next state
    always_comb begin
        a_rise  = pins[2] && !a_prev_q;
        sw_fall = sw_prev_q && !pins[0];
        mode_d  = mode_q;
        nvs_d   = nvs_q;
        cfg_d   = cfg_q;
        sel_d   = sel_q;
        idx_d   = idx_q;
        cnt_d   = cnt_q;
        long_d  = long_q;
        msg_d   = msg_q;
        nv_d    = nv_cmd;
        changed = 1'b0;
        lvl     = cfg_q[sel_q][7:0];
        if (!loading) begin
            // knob push: short press flips mode, long press flips link
            if (pins[0]) begin
                if (cnt_q != LONG_CNT) begin
                    cnt_d = cnt_q + 24'h000001;
                end else if (!long_q) begin
                    long_d = 1'b1;
                    msg_d  = 1'b1;
                    cfg_d[`FPE_CFG_LINK][0] = !cfg_q[`FPE_CFG_LINK][0];
                    changed = 1'b1;
                end
            end else begin
                cnt_d  = 24'h000000;
                long_d = 1'b0;
                if (sw_fall && !long_q) begin
                    mode_d = (mode_q == fpe_pkg::fpe_mode_channel) ?
                             fpe_pkg::fpe_mode_level : fpe_pkg::fpe_mode_channel;
                    msg_d  = 1'b0;
                end
            end
            // rotation: direction taken from b at the a edge
            if (a_rise) begin
                msg_d = 1'b0;
                if (mode_q == fpe_pkg::fpe_mode_channel) begin
                    sel_d = ch_step(sel_q, !pins[1], cfg_q[`FPE_CFG_LINK][0]);
                end else begin
                    if (!pins[1] && lvl != max_idx(sel_q)) begin
                        lvl = lvl + 8'h01;
                    end else if (pins[1] && lvl != 8'h00) begin
                        lvl = lvl - 8'h01;
                    end
                    cfg_d[sel_q] = {8'h00, lvl};
                    if (cfg_q[`FPE_CFG_LINK][0] && paired(sel_q)) begin
                        cfg_d[{sel_q[4:1], 1'b1}] = {8'h00, lvl};
                    end
                    changed = 1'b1;
                end
            end
            // software writes land after the panel so the bus wins a tie
            if (acc && pwrite && hit_cfg) begin
                cfg_d[widx] = clamp_w(widx, pwdata[15:0]);
                changed = 1'b1;
            end
            // link keeps the selection on a left channel, whoever turned it on
            if (cfg_d[`FPE_CFG_LINK][0] && paired(sel_d)) begin
                sel_d = {sel_d[4:1], 1'b0};
            end
        end
        // memory sequencer: restore once, then rewrite the image per change
        case (nvs_q)
            fpe_pkg::fpe_nv_load: begin
                nv_d.req = 1'b1;
                nv_d.we  = 1'b0;
                nv_d.addr = idx_q;
                if (nv_ack) begin
                    cfg_d[idx_q] = clamp_w(idx_q, nv_rdata);
                    idx_d = idx_q + 5'h01;
                    nv_d.addr = idx_d;
                    if (idx_q == `FPE_CFG_LAST) begin
                        nvs_d    = fpe_pkg::fpe_nv_idle;
                        nv_d.req = 1'b0;
                        idx_d    = 5'h00;
                    end
                end
            end
            fpe_pkg::fpe_nv_idle: begin
                if (dirty_q) begin
                    nvs_d = fpe_pkg::fpe_nv_save;
                    nv_d  = '{req: 1'b1, we: 1'b1, addr: 5'h00, wdata: cfg_q[0]};
                end
            end
            fpe_pkg::fpe_nv_save: begin
                if (nv_ack) begin
                    idx_d = idx_q + 5'h01;
                    nv_d.addr  = idx_d;
                    if (idx_q == `FPE_CFG_LAST) begin
                        nvs_d    = fpe_pkg::fpe_nv_idle;
                        nv_d.req = 1'b0;
                        idx_d    = 5'h00;
                    end else begin
                        nv_d.wdata = cfg_q[idx_d]; // no word past the last to fetch
                    end
                end
            end
            default: begin
                nvs_d = fpe_pkg::fpe_nv_idle;
            end
        endcase
        // a change in the cycle of the save start is kept for the next pass
        dirty_d = changed || (dirty_q && nvs_q != fpe_pkg::fpe_nv_idle);
    end

    // display image from the next state
    always_comb begin
        dch = sel_d;
        disp_d.link_msg = msg_d;
        disp_d.link_on  = cfg_d[`FPE_CFG_LINK][0];
        disp_d.mode     = mode_d;
        disp_d.dot      = 1'b0;
        disp_d.mute     = 1'b0;
        dlvl            = cfg_d[dch][7:0];
        if (dch <= `FPE_CH_IN_LAST) begin
            disp_d.cls = fpe_pkg::fpe_input_code;
            disp_d.num = 4'(dch + 5'h01);
        end else if (dch < `FPE_CH_PHONES) begin
            disp_d.cls = fpe_pkg::fpe_line_out_code;
            disp_d.num = 4'(dch - `FPE_CH_LINE_FIRST + 5'h01);
        end else if (dch == `FPE_CH_PHONES) begin
            disp_d.cls = fpe_pkg::phones_pair_code;
            disp_d.num = 4'h0;
        end else if (dch == `FPE_CH_COAX) begin
            disp_d.cls = fpe_pkg::coax_digital_out_code;
            disp_d.num = 4'h0;
        end else begin
            disp_d.cls = fpe_pkg::fpe_optical_code;
            disp_d.num = 4'(dch - `FPE_CH_OPT_FIRST + 5'h01);
        end
        if (dch <= `FPE_CH_MIC_LAST) begin
            // index 0 is the extra 0 dB step below the 10 dB start
            disp_d.db = (dlvl == 8'h00) ? 8'sh00 : $signed(dlvl + `FPE_MIC_DB_OFS);
        end else if (dch <= `FPE_CH_IN_LAST) begin
            disp_d.db  = $signed({1'b0, dlvl[7:1]});
            disp_d.dot = dlvl[0];
        end else begin
            disp_d.mute = (dlvl == `FPE_MUTE_IDX);
            disp_d.db   = disp_d.mute ? 8'sh00 : $signed(dlvl - `FPE_OUT_DB_OFS);
        end
    end

    // all state registers; enable low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= fpe_pkg::fpe_mode_channel;
            nvs_q     <= fpe_pkg::fpe_nv_load;
            cfg_q     <= '{default: `FPE_CFG_RST};
            sel_q     <= 5'h00;
            idx_q     <= 5'h00;
            dirty_q   <= 1'b0;
            cnt_q     <= 24'h000000;
            long_q    <= 1'b0;
            sw_prev_q <= 1'b0;
            a_prev_q  <= 1'b0;
            msg_q     <= 1'b0;
            nv_cmd    <= '0;
            disp      <= '0;
            prdata    <= 32'h0000_0000;
        end else if (ce) begin
            mode_q    <= mode_d;
            nvs_q     <= nvs_d;
            cfg_q     <= cfg_d;
            sel_q     <= sel_d;
            idx_q     <= idx_d;
            dirty_q   <= dirty_d;
            cnt_q     <= cnt_d;
            long_q    <= long_d;
            sw_prev_q <= pins[0];
            a_prev_q  <= pins[2];
            msg_q     <= msg_d;
            nv_cmd    <= nv_d;
            disp      <= disp_d;
            prdata    <= prdata_d;
        end
    end

    // settings toward the analog stage, the mixer and the system
    assign mode_led  = (mode_q == fpe_pkg::fpe_mode_level);
    assign an_gain   = {cfg_q[3][7:0], cfg_q[2][7:0], cfg_q[1][7:0], cfg_q[0][7:0]};
    assign sys_cfg   = cfg_q[`FPE_CFG_SYS];
    assign cfg_ready = !loading;
    for (genvar g = 0; g < 16; g++) begin : g_mix
        assign mix_level[g*8 +: 8] = cfg_q[g + 4][7:0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_short_press;
        ce && sw_fall && !long_q && !loading;
    endsequence

    a_restore_reads: assert property (loading |-> nv_cmd.we == 1'b0 && !pready)
        else $error("restore phase issued a write or took the bus");
    a_save_starts: assert property (ce && dirty_q && nvs_q == fpe_pkg::fpe_nv_idle
        |=> nvs_q == fpe_pkg::fpe_nv_save && nv_cmd.req && nv_cmd.we)
        else $error("pending change did not start a save");
    a_mode_flip: assert property (s_short_press |=> mode_q != $past(mode_q))
        else $error("short press did not change mode");
    a_led_tracks: assert property (ce ##1 mode_led == (disp.mode == fpe_pkg::fpe_mode_level))
        else $error("mode indicator disagrees with display");
    a_link_toggle: assert property (ce && pins[0] && cnt_q == LONG_CNT && !long_q && !loading
        |=> cfg_q[`FPE_CFG_LINK][0] != $past(cfg_q[`FPE_CFG_LINK][0]) && disp.link_msg)
        else $error("long press did not toggle link");
    a_left_only: assert property (cfg_q[`FPE_CFG_LINK][0] && paired(sel_q) |-> !sel_q[0])
        else $error("right channel selected while linked");
    a_pair_copy: assert property (ce && a_rise && !loading && mode_q == fpe_pkg::fpe_mode_level
        && cfg_q[`FPE_CFG_LINK][0] && paired(sel_q) && !(acc && pwrite)
        |=> cfg_q[{sel_q[4:1], 1'b1}] == cfg_q[sel_q])
        else $error("linked right channel not updated");
    a_range_hold: assert property (cfg_q[sel_q][7:0] <= max_idx(sel_q))
        else $error("channel setting out of range");
    a_dot_inst: assert property (disp.dot |-> disp.cls == fpe_pkg::fpe_input_code
        && disp.num > 4'h2)
        else $error("half dB dot on a non instrument channel");
    a_out_span: assert property (disp.cls != fpe_pkg::fpe_input_code && !disp.mute
        |-> disp.db <= 8'sh06 && disp.db >= -8'sd58)
        else $error("output level outside its span");
endmodule

// *** verification/fpe_nv_model.sv ***
// nonvolatile memory model on the far side of the controller's restore and save port
`timescale 1ns/10ps
module fpe_nv_model (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // request side
    input  wire fpe_pkg::fpe_nv_req_t nv_cmd,
    input  wire logic [1:0]           lag,
    output logic                      nv_ack,
    output logic      [15:0]          nv_rdata,
    output int                        wr_cnt
);
    logic [15:0] mem [24]; // stored image, preloaded by the bench
    logic [1:0]  wait_q;   // cycles already waited on this request

    // ack after lag cycles; an idle data line toggles so a stale word never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_ack   <= 1'b0;
            wait_q   <= 2'h0;
            nv_rdata <= 16'h0000;
            wr_cnt   <= 0;
        end else if (nv_cmd.req && !nv_ack && wait_q == lag) begin
            nv_ack   <= 1'b1;
            wait_q   <= 2'h0;
            nv_rdata <= mem[nv_cmd.addr];
            if (nv_cmd.we) begin
                mem[nv_cmd.addr] <= nv_cmd.wdata;
                wr_cnt           <= wr_cnt + 1;
            end
        end else begin
            nv_ack   <= 1'b0;
            wait_q   <= (nv_cmd.req && !nv_ack) ? wait_q + 2'h1 : 2'h0;
            nv_rdata <= ~nv_rdata;
        end
    end
endmodule

// *** verification/front_panel_encoder_control_bench.sv ***
// self-checking bench for the front panel encoder control block
`timescale 1ns/10ps
module front_panel_encoder_control_bench;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd_q, an_gain;
    logic                 enc_a_pin, enc_b_pin, knob_sw_pin, mode_led, nv_ack, cfg_ready;
    logic [15:0]          nv_rdata, sys_cfg;
    logic [127:0]         mix_level;
    logic [1:0]           lag;
    int                   wr_cnt;
    int                   n_fail = 0; // mismatches
    int                   compares = 0; // comparisons made
    fpe_pkg::fpe_disp_t   disp;
    fpe_pkg::fpe_nv_req_t nv_cmd;

    fpe_ctrl #(.LONG_PRESS_CYC(20)) fpe_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a_pin(enc_a_pin),
        .enc_b_pin(enc_b_pin), .knob_sw_pin(knob_sw_pin), .mode_led(mode_led), .disp(disp),
        .nv_cmd(nv_cmd), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .an_gain(an_gain),
        .mix_level(mix_level), .sys_cfg(sys_cfg), .cfg_ready(cfg_ready));
    fpe_nv_model fpe_nv_model_i (.pclk(pclk), .presetn(presetn), .nv_cmd(nv_cmd), .lag(lag),
        .nv_ack(nv_ack), .nv_rdata(nv_rdata), .wr_cnt(wr_cnt));

    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; waits on pready with a bound, since restore stalls the bus
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 5000);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb pready", 32'h1, {31'h0, pready});
    endtask

    // wait four cycles for a save to start, then until the request line has stayed quiet for three cycles
    task automatic wait_save;
        int q;
        q = 0;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 3000 && q < 3; i++) begin
            @(posedge pclk);
            q = nv_cmd.req ? 0 : q + 1;
        end
        #10;
    endtask

    // one detent; b low at the a edge means clockwise
    task automatic step(input logic dn);
        @(posedge pclk);
        enc_b_pin <= dn;
        repeat (6) @(posedge pclk);
        enc_a_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        enc_a_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        #10;
    endtask

    // knob press held for a number of cycles
    task automatic press(input int hold);
        @(posedge pclk);
        knob_sw_pin <= 1'b1;
        repeat (hold) @(posedge pclk);
        knob_sw_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        #10;
    endtask

    // restore with a slow memory, bus stalled meanwhile
    task automatic t_restore;
        apb(1'b0, 12'h150, 32'h0);
        chk("sys word read", 32'h00001234, rd_q);
        chk("restore done", 32'h1, {31'h0, cfg_ready});
        chk("sys_cfg", 32'h1234, {16'h0, sys_cfg});
        chk("mic gain", 32'h05, {24'h0, an_gain[7:0]});
        chk("line level", 32'h20, {24'h0, mix_level[7:0]});
        apb(1'b0, 12'h158, 32'h0);
        chk("mixer spare", 32'h00ab, rd_q);
        $display("restore test done");
    endtask

    // bus write saved at once; unmapped and read-only refused
    task automatic t_save;
        lag <= 2'h0;
        apb(1'b1, 12'h110, 32'h30);
        wait_save();
        chk("saved word", 32'h30, {16'h0, fpe_nv_model_i.mem[4]});
        chk("save words", 32'd24, wr_cnt);
        chk("applied", 32'h30, {24'h0, mix_level[7:0]});
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err_q});
        apb(1'b1, 12'h000, 32'hff);
        chk("status wr err", 32'h1, {31'h0, err_q});
        apb(1'b1, 12'h110, 32'h01);
        $display("save test done");
    endtask

    // mode toggle and mic range ends
    task automatic t_mic;
        press(10);
        chk("mode led", 32'h1, {31'h0, mode_led});
        chk("disp mode", 32'h1, {31'h0, disp.mode});
        step(1'b0);
        chk("mic up", 32'h06, {24'h0, an_gain[7:0]});
        chk("mic db", 32'h0f, {24'h0, disp.db});
        apb(1'b1, 12'h100, 32'h38);
        step(1'b0);
        chk("mic top", 32'h38, {24'h0, an_gain[7:0]});
        apb(1'b1, 12'h100, 32'h01);
        step(1'b1);
        chk("mic zero db", 32'h00, {24'h0, disp.db});
        $display("mic test done");
    endtask

    // channel stepping and half dB dot
    task automatic t_inst;
        press(10);
        chk("mode back", 32'h0, {31'h0, mode_led});
        step(1'b0);
        step(1'b0);
        chk("input class", {29'h0, fpe_pkg::fpe_input_code}, {29'h0, disp.cls});
        chk("input number", 32'h3, {28'h0, disp.num});
        apb(1'b1, 12'h108, 32'h07);
        press(10);
        chk("inst db", 32'h03, {24'h0, disp.db});
        chk("inst dot", 32'h1, {31'h0, disp.dot});
        step(1'b0);
        chk("inst whole", 32'h0, {31'h0, disp.dot});
        $display("instrument test done");
    endtask

    // long press link, pair copy, left-only selection, mute below lowest step
    task automatic t_link;
        press(40);
        chk("link on", 32'h3, {30'h0, disp.link_msg, disp.link_on});
        chk("mode kept", 32'h1, {31'h0, mode_led});
        step(1'b0);
        chk("right copy", 32'h09, {24'h0, an_gain[31:24]});
        wait_save();
        chk("right saved", 32'h09, {16'h0, fpe_nv_model_i.mem[3]});
        press(10);
        step(1'b0);
        apb(1'b0, 12'h000, 32'h0);
        chk("left only", 32'h04, {27'h0, rd_q[12:8]});
        press(10);
        step(1'b0);
        chk("pair up", 32'h0202, {16'h0, mix_level[15:0]});
        step(1'b1);
        step(1'b1);
        chk("mute", 32'h0, {24'h0, mix_level[7:0]});
        chk("mute shown", 32'h1, {31'h0, disp.mute});
        step(1'b1);
        chk("mute hold", 32'h0, {24'h0, mix_level[7:0]});
        $display("link test done");
    endtask

    // verdict
    task automatic conclude;
        $display("counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        conclude();
    end

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {enc_a_pin, enc_b_pin, knob_sw_pin} = 3'h0;
        lag = 2'h2;
        #1;
        foreach (fpe_nv_model_i.mem[i]) fpe_nv_model_i.mem[i] = 16'h0000;
        fpe_nv_model_i.mem[0] = 16'h0005;
        fpe_nv_model_i.mem[4] = 16'h0020;
        fpe_nv_model_i.mem[20] = 16'h1234;
        fpe_nv_model_i.mem[22] = 16'h00ab;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_restore();
        t_save();
        t_mic();
        t_inst();
        t_link();
        conclude();
    end
endmodule
